/* hw/mcmi_top.sv */
/*
  Command-mode front end: escape detection with guard silences, strap
  entry at reset, text command line parsing and binary command mode.
  Assumes a UART outside that delivers whole bytes at stop-bit end
  and a parameter store that answers each request with ack and status.
*/
// How it works
// R1: Silence of pre-guard before escape characters
// R2: Exactly three sequence characters follow silence
// R3: Post-guard silence then enters command mode
// R4: Strap low at reset enters text mode
// R5: Empty parameter field means read request
// R6: Writes touch working value; commit stores
// R7: Each text command answered OK or ERROR; a successful read is answered with its value instead
// R8: Comma-separated commands, AT once, CR ends
// R9: Leave on leave command or timeout
// R10: Binary select sampled at byte stop end
// R11: Binary commands run in arrival order
// R12: Wait for receive gap before executing
// R13: Clear-to-send high while binary command executes
// R14: Host holds select 100 us after byte
// R15: Missing parameters within 0.5 s abandon
// R16: Parameters two bytes, low byte first
// R17: Bit 0x80 without parameters is query
// R18: Select honoured only when line-two function 1
// R19: Host raises select to enter binary
// R20: Host avoids hardware flow control then
// R21: Stray character aborts escape, restarts silence
`timescale 1ns/1ps
module mcmi_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic setup_strap_n,
  input wire logic binary_mode_select,
  input wire mcmi_pkg::mcmi_byte_t rx_byte,
  input wire logic radio_rx_busy,
  input wire logic [15:0] pre_guard_silence,
  input wire logic [15:0] post_guard_silence,
  input wire logic [7:0] sequence_character,
  input wire logic [15:0] command_timeout,
  input wire logic [1:0] input_line_two_function,
  input wire logic [7:0] leave_command_mode,
  input wire logic [7:0] commit_to_nonvolatile,
  output mcmi_pkg::mcmi_byte_t payload_out,
  output mcmi_pkg::mcmi_req_t param_req,
  input wire logic param_ack,
  input wire logic param_ok,
  input wire logic [15:0] param_value,
  output logic commit_req,
  output mcmi_pkg::mcmi_rsp_t response,
  output logic clear_to_send,
  output logic command_mode,
  output logic default_baud
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] strap_s_q, strap_s_d, sel_s_q, sel_s_d;
  always_comb
  begin
    strap_s_d = {strap_s_q[0], setup_strap_n};
    sel_s_d = {sel_s_q[0], binary_mode_select};
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      strap_s_q <= 2'h3;
      sel_s_q <= 2'h0;
    end
    else
    begin
      strap_s_q <= strap_s_d;
      sel_s_q <= sel_s_d;
    end
  end

  // ----------------------------------------------------------------
  // Escape detection and text command mode
  // ----------------------------------------------------------------
  typedef enum {ESC_SILENT, ESC_CHARS, ESC_POST} mcmi_esc_t;
  typedef enum {TX_IDLE, TX_SEEK_A, TX_SEEK_T, TX_CODE, TX_PARAM, TX_WAIT} mcmi_txt_t;
  localparam logic [22:0] UNIT = 23'(mcmi_pkg::GUARD_UNIT_CYC);

  mcmi_esc_t esc_q, esc_d;
  mcmi_txt_t txt_q, txt_d;
  logic [22:0] tick_q, tick_d;
  logic [15:0] units_q, units_d, idle_q, idle_d, val_q, val_d;
  logic [1:0] nseq_q, nseq_d, nlet_q, nlet_d, wake_q, wake_d;
  logic cmd_q, cmd_d, baud_q, baud_d;
  logic has_val_q, has_val_d, last_q, last_d, err_q, err_d, commit_q, commit_d;
  logic [7:0] code_q, code_d;
  logic [3:0] hexv;
  logic is_hex, unit_tick, bin_byte;
  mcmi_pkg::mcmi_req_t treq_q, treq_d;
  mcmi_pkg::mcmi_rsp_t trsp_q, trsp_d;

  always_comb
  begin
    is_hex = 1'b1;
    hexv = rx_byte.data[3:0];
    if (rx_byte.data >= 8'h41 && rx_byte.data <= 8'h46)
      hexv = 4'(rx_byte.data[3:0] + 4'h9);
    else if (rx_byte.data < 8'h30 || rx_byte.data > 8'h39)
      is_hex = 1'b0;
  end

  assign unit_tick = (tick_q == UNIT - 23'h1);

  always_comb
  begin
    esc_d = esc_q;
    txt_d = txt_q;
    tick_d = unit_tick ? 23'h0 : 23'(tick_q + 23'h1);
    units_d = unit_tick ? 16'(units_q + 16'h1) : units_q;
    idle_d = idle_q;
    nseq_d = nseq_q;
    nlet_d = nlet_q;
    cmd_d = cmd_q;
    baud_d = baud_q;
    wake_d = (wake_q == 2'h3) ? wake_q : 2'(wake_q + 2'h1);
    val_d = val_q;
    code_d = code_q;
    has_val_d = has_val_q;
    last_d = last_q;
    err_d = err_q;
    commit_d = 1'b0;
    treq_d = treq_q;
    treq_d.valid = 1'b0;
    trsp_d = '0;
    // Strap is read once the synchroniser holds a real pin sample, not its reset value
    if (wake_q == 2'h2 && !strap_s_q[1])
    begin
      cmd_d = 1'b1; // [R4]
      baud_d = 1'b1; // [R4]
      txt_d = TX_SEEK_A;
    end
    if (!cmd_q)
    begin
      if (rx_byte.valid && !bin_byte)
      begin
        tick_d = '0;
        units_d = '0;
        if (esc_q == ESC_SILENT && units_q >= pre_guard_silence) // [R1]
        begin
          esc_d = (rx_byte.data == sequence_character) ? ESC_CHARS : ESC_SILENT;
          nseq_d = 2'h1;
        end
        else if (esc_q == ESC_CHARS && rx_byte.data == sequence_character)
        begin
          nseq_d = 2'(nseq_q + 2'h1); // [R2]
          esc_d = (nseq_q + 2'h1 == mcmi_pkg::ESC_COUNT) ? ESC_POST : ESC_CHARS;
        end
        else
          esc_d = ESC_SILENT; // [R21]
      end
      else if (esc_q == ESC_POST && units_q >= post_guard_silence)
      begin
        cmd_d = 1'b1; // [R3]
        esc_d = ESC_SILENT;
        txt_d = TX_SEEK_A;
        idle_d = '0;
        trsp_d.kind = mcmi_pkg::MCMI_RSP_OK;
      end
    end
    else
    begin
      if (unit_tick)
        idle_d = 16'(idle_q + 16'h1);
      if (idle_q >= command_timeout && txt_q != TX_WAIT)
      begin
        cmd_d = 1'b0; // [R9]
        baud_d = 1'b0;
        txt_d = TX_IDLE;
      end
      else if (txt_q == TX_WAIT)
      begin
        if (param_ack)
        begin
          trsp_d.value = param_value;
          trsp_d.kind = !param_ok ? mcmi_pkg::MCMI_RSP_ERROR // [R7]
                      : (treq_q.write ? mcmi_pkg::MCMI_RSP_OK : mcmi_pkg::MCMI_RSP_VALUE);
          idle_d = '0;
          txt_d = last_q ? TX_SEEK_A : TX_CODE;
        end
      end
      else if (rx_byte.valid && !bin_byte)
      begin
        case (txt_q)
          TX_SEEK_A: txt_d = (rx_byte.data == mcmi_pkg::CH_A) ? TX_SEEK_T : TX_SEEK_A;
          TX_SEEK_T: // [R8]
          begin
            txt_d = (rx_byte.data == mcmi_pkg::CH_T) ? TX_CODE : TX_SEEK_A;
            code_d = '0;
            val_d = '0;
            has_val_d = 1'b0;
            err_d = 1'b0;
            nlet_d = 2'h0;
          end
          TX_CODE, TX_PARAM:
          begin
            if (rx_byte.data == mcmi_pkg::CH_CR || rx_byte.data == mcmi_pkg::CH_COMMA)
            begin
              last_d = (rx_byte.data == mcmi_pkg::CH_CR); // [R8]
              if (err_q)
              begin
                trsp_d.kind = mcmi_pkg::MCMI_RSP_ERROR; // [R7]
                txt_d = last_d ? TX_SEEK_A : TX_CODE;
              end
              else if (code_q == leave_command_mode)
              begin
                trsp_d.kind = mcmi_pkg::MCMI_RSP_OK; // [R7]
                cmd_d = 1'b0; // [R9]
                baud_d = 1'b0;
                txt_d = TX_IDLE;
              end
              else if (code_q == commit_to_nonvolatile)
              begin
                commit_d = 1'b1; // [R6]
                trsp_d.kind = mcmi_pkg::MCMI_RSP_OK;
                txt_d = last_d ? TX_SEEK_A : TX_CODE;
              end
              else
              begin
                treq_d.valid = 1'b1;
                treq_d.write = has_val_q; // [R5] [R6]
                treq_d.code = code_q;
                treq_d.value = val_q;
                txt_d = TX_WAIT;
              end
              idle_d = '0;
              code_d = '0;
              val_d = '0;
              has_val_d = 1'b0;
              err_d = 1'b0;
              nlet_d = 2'h0;
            end
            else if (rx_byte.data == mcmi_pkg::CH_SPACE)
              txt_d = (nlet_q == 2'h0) ? txt_q : TX_PARAM; // [R8]
            else if (txt_q == TX_CODE && !has_val_q && nlet_q != 2'h2)
            begin
              code_d = {code_q[5:0], 2'h0} ^ rx_byte.data; // Two letters folded to a code
              nlet_d = 2'(nlet_q + 2'h1);
            end
            else if (is_hex)
            begin
              val_d = {val_q[11:0], hexv};
              has_val_d = 1'b1;
              txt_d = TX_PARAM;
            end
            else
              err_d = 1'b1;
          end
          default: txt_d = TX_SEEK_A;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      esc_q <= ESC_SILENT;
      txt_q <= TX_IDLE;
      tick_q <= '0;
      units_q <= '0;
      idle_q <= '0;
      nseq_q <= '0;
      nlet_q <= '0;
      cmd_q <= 1'b0;
      baud_q <= 1'b0;
      wake_q <= '0;
      val_q <= '0;
      code_q <= '0;
      has_val_q <= 1'b0;
      last_q <= 1'b0;
      err_q <= 1'b0;
      commit_q <= 1'b0;
      treq_q <= '0;
      trsp_q <= '0;
    end
    else
    begin
      esc_q <= esc_d;
      txt_q <= txt_d;
      tick_q <= tick_d;
      units_q <= units_d;
      idle_q <= idle_d;
      nseq_q <= nseq_d;
      nlet_q <= nlet_d;
      cmd_q <= cmd_d;
      baud_q <= baud_d;
      wake_q <= wake_d;
      val_q <= val_d;
      code_q <= code_d;
      has_val_q <= has_val_d;
      last_q <= last_d;
      err_q <= err_d;
      commit_q <= commit_d;
      treq_q <= treq_d;
      trsp_q <= trsp_d;
    end
  end

  // ----------------------------------------------------------------
  // Binary command mode
  // ----------------------------------------------------------------
  typedef enum {BN_IDLE, BN_LO, BN_HI, BN_GAP, BN_EXEC} mcmi_bin_t;
  localparam logic [23:0] BIN_TO = 24'(mcmi_pkg::BIN_TIMEOUT_CYC);

  mcmi_bin_t bin_q, bin_d;
  logic [23:0] bto_q, bto_d;
  logic [7:0] bcode_q, bcode_d;
  logic [15:0] bval_q, bval_d;
  logic bwrite_q, bwrite_d, cts_q, cts_d;
  mcmi_pkg::mcmi_req_t breq_q, breq_d;
  mcmi_pkg::mcmi_byte_t pay_q, pay_d;

  // Select is the synchronised level at the byte's stop-bit end
  assign bin_byte = sel_s_q[1] && (input_line_two_function == mcmi_pkg::LINE2_BINARY); // [R10] [R18]

  always_comb
  begin
    bin_d = bin_q;
    bto_d = 24'(bto_q + 24'h1);
    bcode_d = bcode_q;
    bval_d = bval_q;
    bwrite_d = bwrite_q;
    breq_d = breq_q;
    breq_d.valid = 1'b0;
    cts_d = 1'b0;
    pay_d.valid = rx_byte.valid && !bin_byte && !cmd_q;
    pay_d.data = rx_byte.data;
    case (bin_q)
      BN_IDLE:
        if (rx_byte.valid && bin_byte) // [R11]
        begin
          bcode_d = rx_byte.data;
          bto_d = '0;
          bval_d = '0;
          bwrite_d = !rx_byte.data[7]; // [R17]
          bin_d = rx_byte.data[7] ? BN_GAP : BN_LO;
        end
      BN_LO, BN_HI:
        if (bto_q >= BIN_TO - 24'h1)
          bin_d = BN_IDLE; // [R15]
        else if (rx_byte.valid && bin_byte)
        begin
          if (bin_q == BN_LO)
            bval_d[7:0] = rx_byte.data; // [R16]
          else
            bval_d[15:8] = rx_byte.data; // [R16]
          bin_d = (bin_q == BN_LO) ? BN_HI : BN_GAP;
        end
      BN_GAP:
        if (!radio_rx_busy) // [R12]
        begin
          breq_d.valid = 1'b1;
          breq_d.write = bwrite_q;
          breq_d.code = bcode_q & ~mcmi_pkg::QUERY_BIT;
          breq_d.value = bval_q;
          cts_d = 1'b1;
          bin_d = BN_EXEC;
        end
      BN_EXEC:
      begin
        cts_d = !param_ack; // [R13]
        if (param_ack)
          bin_d = BN_IDLE;
      end
      default: bin_d = BN_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bin_q <= BN_IDLE;
      bto_q <= '0;
      bcode_q <= '0;
      bval_q <= '0;
      bwrite_q <= 1'b0;
      breq_q <= '0;
      cts_q <= 1'b0;
      pay_q <= '0;
    end
    else
    begin
      bin_q <= bin_d;
      bto_q <= bto_d;
      bcode_q <= bcode_d;
      bval_q <= bval_d;
      bwrite_q <= bwrite_d;
      breq_q <= breq_d;
      cts_q <= cts_d;
      pay_q <= pay_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Both requesters share one store port; text and binary never overlap in practice
  assign param_req = breq_q.valid ? breq_q : treq_q;
  assign response = (bin_q == BN_EXEC && param_ack)
                  ? mcmi_pkg::mcmi_rsp_t'{kind: mcmi_pkg::MCMI_RSP_VALUE, value: param_value}
                  : trsp_q;
  assign clear_to_send = cts_q;
  assign commit_req = commit_q;
  assign command_mode = cmd_q;
  assign default_baud = baud_q;
  assign payload_out = pay_q;

endmodule

/* hw/mcmi_pkg.sv */
/*
  Package for the command-mode interpreter: timing counts, defaults,
  character codes and the carrier structs shared by the design.
  Assumes a 20 MHz system clock.
*/
package mcmi_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned GUARD_UNIT_MS = 100;
  localparam int unsigned GUARD_UNIT_CYC = CLK_HZ / 1000 * GUARD_UNIT_MS;
  localparam int unsigned BIN_TIMEOUT_MS = 500;
  localparam int unsigned BIN_TIMEOUT_CYC = CLK_HZ / 1000 * BIN_TIMEOUT_MS;
  localparam int unsigned CMD_HOLD_US = 100;
  localparam int unsigned CMD_HOLD_CYC = CLK_HZ / 1000000 * CMD_HOLD_US;

  // ----------------------------------------------------------------
  // Defaults and characters
  // ----------------------------------------------------------------
  localparam logic [15:0] PRE_GUARD_RST = 16'h000a;
  localparam logic [15:0] POST_GUARD_RST = 16'h000a;
  localparam logic [7:0] SEQ_CHAR_RST = 8'h2d;
  localparam logic [15:0] CMD_TIMEOUT_RST = 16'h0064;
  localparam logic [7:0] QUERY_BIT = 8'h80;
  localparam logic [1:0] ESC_COUNT = 2'h3;
  localparam logic [1:0] LINE2_BINARY = 2'h1;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_SPACE = 8'h20;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mcmi_byte_t;

  // One parsed command toward the parameter store
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] value;
  } mcmi_req_t;

  typedef enum logic [1:0] {
    MCMI_RSP_NONE,
    MCMI_RSP_OK,
    MCMI_RSP_ERROR,
    MCMI_RSP_VALUE
  } mcmi_rsp_kind_t;

  typedef struct packed {
    mcmi_rsp_kind_t kind;
    logic [15:0] value;
  } mcmi_rsp_t;

endpackage

/* sim/mcmi_chk_sva.sv */
/*
  Port-level checker for mcmi_top: handshake framing, pulse widths
  and mode entry. Assumes one clock domain and a bind to every mcmi_top.
*/
`timescale 1ns/1ps
module mcmi_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire mcmi_pkg::mcmi_byte_t rx_byte,
  input wire logic radio_rx_busy,
  input wire logic [1:0] input_line_two_function,
  input wire mcmi_pkg::mcmi_byte_t payload_out,
  input wire mcmi_pkg::mcmi_req_t param_req,
  input wire logic param_ack,
  input wire logic commit_req,
  input wire mcmi_pkg::mcmi_rsp_t response,
  input wire logic clear_to_send,
  input wire logic command_mode,
  input wire logic default_baud
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_strap_mode: assert property ($rose(default_baud) |-> command_mode)
    else $error("default baud without command mode");
  a_payload_cause: assert property (payload_out.valid |-> $past(rx_byte.valid))
    else $error("payload without a received byte");
  a_req_pulse: assert property (param_req.valid |=> !param_req.valid)
    else $error("request longer than one cycle");
  a_cts_start: assert property ($rose(clear_to_send) |-> param_req.valid)
    else $error("clear to send rose without a request");
  a_cts_hold: assert property (clear_to_send && !param_ack |=> clear_to_send)
    else $error("clear to send dropped before the answer");
  a_cts_drop: assert property (clear_to_send && param_ack |=> !clear_to_send)
    else $error("clear to send stayed after the answer");
  a_busy_wait: assert property ($rose(clear_to_send) |-> !$past(radio_rx_busy))
    else $error("binary command ran during radio receive");
  a_bin_enable: assert property ($rose(clear_to_send)
    |-> input_line_two_function == mcmi_pkg::LINE2_BINARY)
    else $error("binary command while select disabled");
  a_ack_answer: assert property (param_ack
    |-> ##[0:1] response.kind != mcmi_pkg::MCMI_RSP_NONE)
    else $error("no response after store answer");
  a_commit_pulse: assert property (commit_req |=> !commit_req)
    else $error("commit longer than one cycle");
  a_escape_ok: assert property ($rose(command_mode) && !default_baud
    |-> ##[0:1] response.kind == mcmi_pkg::MCMI_RSP_OK)
    else $error("command mode entered without OK");
endmodule
bind mcmi_top mcmi_chk chk_u (.clk(clk), .rstn(rstn), .rx_byte(rx_byte),
  .radio_rx_busy(radio_rx_busy), .input_line_two_function(input_line_two_function),
  .payload_out(payload_out), .param_req(param_req), .param_ack(param_ack),
  .commit_req(commit_req), .response(response), .clear_to_send(clear_to_send),
  .command_mode(command_mode), .default_baud(default_baud));

/* sim/mcmi_store_model.sv */
/*
  Parameter store standing behind mcmi_top: holds working values.
  Assumes one request outstanding; lat adds answer delay cycles.
*/
`timescale 1ns/1ps
module mcmi_store_model (
  input wire logic clk,
  input wire logic rstn,
  input wire mcmi_pkg::mcmi_req_t param_req,
  input wire logic [3:0] lat,
  output logic param_ack,
  output logic param_ok,
  output logic [15:0] param_value
);
  logic [15:0] mem [256];
  mcmi_pkg::mcmi_req_t held;
  int wait_n;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      param_ack <= 1'b0;
      param_ok <= 1'b0;
      param_value <= 16'h0000;
      wait_n <= -1;
      foreach (mem[i]) mem[i] <= 16'h0000;
    end
    else
    begin
      param_ack <= 1'b0;
      // Idle data keeps toggling so a stale value is never mistaken for an answer
      param_value <= ~param_value;
      if (param_req.valid)
      begin
        held <= param_req;
        wait_n <= lat;
      end
      else if (wait_n > 0)
        wait_n <= wait_n - 1;
      else if (wait_n == 0)
      begin
        wait_n <= -1;
        param_ack <= 1'b1;
        param_ok <= !held.write || held.value != 16'hdead;
        param_value <= mem[held.code];
        if (held.write && held.value != 16'hdead)
          mem[held.code] <= held.value;
      end
    end
  end
endmodule

/* sim/modem_command_mode_interpreter_tb.sv */
/*
  Self-checking bench for mcmi_top with a queue-based reference.
  Assumes zero guard silences; second-scale timeouts are never reached.
*/
`timescale 1ns/1ps
module modem_command_mode_interpreter_tb;
  logic clk, rstn, strap_n, sel, busy, ack, ok, commit_req, cts, cmd_mode, dflt_baud;
  logic pend, mon_on, pay_on;
  logic [1:0] ilt;
  logic [3:0] lat;
  logic [7:0] addr_c, wr_c, leave_c;
  logic [15:0] pval, v;
  logic [24:0] er;
  logic [18:0] es;
  logic [31:0] seed = 32'h267a;
  mcmi_pkg::mcmi_byte_t rx, pay;
  mcmi_pkg::mcmi_req_t req;
  mcmi_pkg::mcmi_rsp_t rsp;
  logic [24:0] exp_req [$];
  logic [18:0] exp_rsp [$];
  logic [8:0] exp_pay [$];
  int error_cnt, compares, commits;
  mcmi_top dut_u (.clk(clk), .rstn(rstn), .setup_strap_n(strap_n), .binary_mode_select(sel),
    .rx_byte(rx), .radio_rx_busy(busy), .pre_guard_silence(16'h0000),
    .post_guard_silence(16'h0000), .sequence_character(mcmi_pkg::SEQ_CHAR_RST),
    .command_timeout(mcmi_pkg::CMD_TIMEOUT_RST), .input_line_two_function(ilt),
    .leave_command_mode(leave_c), .commit_to_nonvolatile(wr_c), .payload_out(pay),
    .param_req(req), .param_ack(ack), .param_ok(ok), .param_value(pval),
    .commit_req(commit_req), .response(rsp), .clear_to_send(cts),
    .command_mode(cmd_mode), .default_baud(dflt_baud));
  mcmi_store_model store_u (.clk(clk), .rstn(rstn), .param_req(req), .lat(lat),
    .param_ack(ack), .param_ok(ok), .param_value(pval));
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  function automatic logic [7:0] fold(logic [7:0] a, logic [7:0] b);
    return {a[5:0], 2'b00} ^ b;
  endfunction
  task automatic chk(string name, logic [31:0] e, logic [31:0] g);
    compares++;
    if (e !== g)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask
  // Bytes during an outstanding request are refused, so wait it out first
  task automatic send(logic [7:0] d);
    repeat (100) if (pend === 1'b1) @(negedge clk);
    @(negedge clk);
    rx <= {1'b1, d};
    @(negedge clk);
    rx <= '0;
    repeat (3) @(negedge clk);
  endtask
  task automatic line(string s);
    foreach (s[i]) send(s[i]);
  endtask
  task automatic tline(string s);
    line({"AT", s});
    send(mcmi_pkg::CH_CR);
  endtask
  task automatic ersp(logic [1:0] k, logic c, logic [15:0] val);
    exp_rsp.push_back({k, c, val});
  endtask
  task automatic settle(string name);
    repeat (300) if (exp_req.size() + exp_rsp.size() + exp_pay.size() != 0) @(negedge clk);
    chk("queues drained", 0, exp_req.size() + exp_rsp.size() + exp_pay.size());
    repeat (4) @(negedge clk);
    $display("%s done", name);
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    #(50 * 20000);
    error_cnt++;
    $display("[FAIL] watchdog expected finish seen hang");
    final_report();
  end
  always @(negedge clk)
    if (mon_on)
    begin
      if (req.valid !== 1'b0)
      begin
        pend = 1'b1;
        er = exp_req.size() ? exp_req.pop_front() : 25'h1ffffff;
        chk("request", er, {req.write, req.code, er[24] ? req.value : er[15:0]});
        chk("clear to send", sel && ilt == mcmi_pkg::LINE2_BINARY, cts);
      end
      if (rsp.kind !== mcmi_pkg::MCMI_RSP_NONE)
      begin
        pend = 1'b0;
        es = exp_rsp.size() ? exp_rsp.pop_front() : 19'h7ffff;
        chk("response", es, {rsp.kind, es[16], es[16] ? rsp.value : es[15:0]});
      end
      if (pay.valid !== 1'b0 && pay_on)
        chk("payload", exp_pay.size() ? exp_pay.pop_front() : 9'h100, pay.data);
      if (commit_req !== 1'b0)
        commits++;
    end
  initial
  begin
    {rstn, sel, busy, ilt, lat, pend, mon_on, pay_on} = '0;
    strap_n = 1'b0;
    rx = '0;
    addr_c = fold("T", "A");
    wr_c = fold("W", "R");
    leave_c = fold("L", "V");
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    chk("strap entry", 2'b11, {cmd_mode, dflt_baud});
    strap_n = 1'b1;
    mon_on = 1'b1;
    lat = 4'(rnd() & 16'h3);
    exp_req.push_back({1'b0, addr_c, 16'h0000});
    ersp(mcmi_pkg::MCMI_RSP_VALUE, 1'b1, 16'h0000);
    tline("TA");
    exp_req.push_back({1'b1, addr_c, 16'hdead});
    ersp(mcmi_pkg::MCMI_RSP_ERROR, 1'b0, 16'h0000);
    tline("TADEAD");
    exp_req.push_back({1'b1, addr_c, 16'h1a0d});
    repeat (3) ersp(mcmi_pkg::MCMI_RSP_OK, 1'b0, 16'h0000);
    tline("TA1A0D, WR,LV");
    settle("text");
    chk("commit pulses", 1, commits);
    chk("left command mode", 0, cmd_mode);
    pay_on = 1'b1;
    v = rnd() | 16'h0080;
    exp_pay.push_back(v[7:0]);
    send(v[7:0]);
    settle("payload");
    pay_on = 1'b0;
    line("--x-");
    repeat (20) @(negedge clk);
    chk("aborted escape", 0, cmd_mode);
    ersp(mcmi_pkg::MCMI_RSP_OK, 1'b0, 16'h0000);
    line("--");
    settle("escape");
    chk("escape entry", 1, cmd_mode);
    ersp(mcmi_pkg::MCMI_RSP_OK, 1'b0, 16'h0000);
    tline("LV");
    settle("leave");
    ilt = mcmi_pkg::LINE2_BINARY;
    lat = 4'h3;
    pay_on = 1'b1;
    v = rnd();
    exp_pay.push_back(v[7:0]);
    send(v[7:0]);
    sel = 1'b1; // bytes never wait on clear to send
    busy = 1'b1;
    repeat (4) @(negedge clk);
    v = rnd() & 16'h7fff;
    send(8'h00);
    send(v[7:0]);
    send(v[15:8]);
    repeat (20) @(negedge clk);
    exp_req.push_back({1'b1, 8'h00, v});
    ersp(mcmi_pkg::MCMI_RSP_VALUE, 1'b0, 16'h0000);
    busy = 1'b0;
    settle("binary write");
    exp_req.push_back({1'b0, 8'h00, 16'h0000});
    ersp(mcmi_pkg::MCMI_RSP_VALUE, 1'b1, v);
    send(mcmi_pkg::QUERY_BIT);
    settle("binary query");
    repeat (mcmi_pkg::CMD_HOLD_CYC) @(negedge clk);
    sel = 1'b0;
    ilt = 2'h0;
    repeat (4) @(negedge clk);
    sel = 1'b1;
    repeat (4) @(negedge clk);
    exp_pay.push_back(9'h000);
    send(8'h00);
    settle("select disabled");
    sel = 1'b0;
    final_report();
  end
endmodule
